// ===== rtl/flash_bus_cycle.sv
// Single bus cycle engine: one write or one read on the flash pins.
// Assumes the flash answers within READ_CYC clocks of the output gate.
module flash_bus_cycle
    import flash_host_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] i_dq,
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_rdata,
    output pins_t o_pins
);
    typedef enum logic [1:0] {S_IDLE, S_STROBE, S_GAP} cyc_state_t;
    cyc_state_t state_q;
    logic [3:0] cnt_q;
    logic write_q;

    ////////////////////////////////////////////////////////////////////////
    // Sequencing of one cycle
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            write_q <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            unique case (state_q)
                S_IDLE: if (i_start) begin
                    state_q <= S_STROBE;
                    write_q <= i_write;
                    // Strobe long enough to beat the glitch filter
                    cnt_q <= i_write ? 4'(STROBE_CYC) : 4'(READ_CYC);
                end
                S_STROBE: if (cnt_q == 4'h1) begin
                    state_q <= S_GAP;
                end else begin
                    cnt_q <= cnt_q - 4'h1;
                end
                S_GAP: begin
                    state_q <= S_IDLE;
                    o_done <= 1'b1;
                end
            endcase
        end
    end

    // Pins; write strobe and output gate never low together
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                        addr: '0, dq_o: 8'h00, dq_oe: 1'b0};
        end else if (state_q == S_IDLE && i_start) begin
            o_pins.ce_n <= 1'b0;
            o_pins.oe_n <= i_write;
            o_pins.we_n <= ~i_write;
            o_pins.addr <= i_addr;
            o_pins.dq_o <= i_wdata;
            o_pins.dq_oe <= i_write;
        end else if (state_q == S_STROBE && cnt_q == 4'h1) begin
            // Release all strobes; the flash holds what it captured
            o_pins.ce_n <= 1'b1;
            o_pins.oe_n <= 1'b1;
            o_pins.we_n <= 1'b1;
            o_pins.dq_oe <= 1'b0;
        end
    end

    // Read data sampled just before the output gate rises
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (state_q == S_STROBE && cnt_q == 4'h1 && !write_q) begin
            o_rdata <= i_dq;
        end
    end

    assign o_busy = (state_q != S_IDLE);
endmodule

// ===== rtl/flash_host_ctrl.sv
// Host-side flash controller: command sequences, status polling, ID mode.
// Assumes a byte-wide flash on plain pins; the bench resolves the data wire.
//////////////////////////////////////////////////////////////////////////////
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W
)(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    input wire req_t i_req,
    output logic o_req_ready,
    output logic o_resp_valid,
    output logic [7:0] o_resp_data,
    output logic o_id_mode,
    output logic o_flash_ce_n,
    output logic o_flash_oe_n,
    output logic o_flash_we_n,
    output logic [ADDR_WIDTH-1:0] o_flash_addr,
    input wire logic [7:0] i_flash_dq,
    output logic [7:0] o_flash_dq,
    output logic o_flash_dq_oe
);
    typedef enum logic [2:0] {
        H_IDLE, H_ISSUE, H_WAIT, H_POLL_ISSUE, H_POLL_WAIT, H_FINISH
    } host_state_t;

    host_state_t state_q;
    req_t req_q;
    logic [2:0] step_q;
    logic [2:0] steps_total;
    logic have_prev_q;
    logic [7:0] prev_q;
    logic cyc_start;
    logic cyc_write;
    logic [ADDR_W-1:0] cyc_addr;
    logic [7:0] cyc_data;
    logic cyc_done;
    logic [7:0] cyc_rdata;
    pins_t pins;

    //////////////////////////////////////////////////////////////////////////
    // Bus cycle steps per operation
    always_comb begin
        unique case (req_q.op)
            OP_READ: steps_total = 3'd1;
            OP_PROGRAM: steps_total = 3'd4;
            OP_SECTOR_ERASE: steps_total = 3'd6;
            OP_CHIP_ERASE: steps_total = 3'd6;
            OP_ID_ENTRY: steps_total = 3'd3;
            OP_ID_EXIT_SHORT: steps_total = 3'd1;
            OP_ID_EXIT_LONG: steps_total = 3'd3;
            default: steps_total = 3'd1;
        endcase
    end

    // Address and data of the current step of the sequence
    always_comb begin
        cyc_addr = ADDR_W'(UNLOCK_ADDR1);
        cyc_data = UNLOCK_DATA1;
        unique case (step_q)
            3'd0, 3'd3: begin
                cyc_addr = ADDR_W'(UNLOCK_ADDR1);
                cyc_data = UNLOCK_DATA1;
            end
            3'd1, 3'd4: begin
                cyc_addr = ADDR_W'(UNLOCK_ADDR2);
                cyc_data = UNLOCK_DATA2;
            end
            3'd2: begin
                cyc_addr = ADDR_W'(UNLOCK_ADDR1);
                unique case (req_q.op)
                    OP_PROGRAM: cyc_data = CMD_PROGRAM;
                    OP_ID_ENTRY: cyc_data = CMD_ID_ENTRY;
                    OP_ID_EXIT_LONG: cyc_data = CMD_ID_EXIT;
                    default: cyc_data = CMD_ERASE_SETUP;
                endcase
            end
            3'd5: begin
                if (req_q.op == OP_CHIP_ERASE) begin
                    cyc_addr = ADDR_W'(UNLOCK_ADDR1);
                    cyc_data = CMD_CHIP_ERASE;
                end else begin
                    // Sector picked by the upper address lines only
                    cyc_addr = {req_q.addr[ADDR_W-1:SECTOR_LSB],
                                {SECTOR_LSB{1'b0}}};
                    cyc_data = CMD_SECTOR_ERASE;
                end
            end
            default: begin
                cyc_addr = ADDR_W'(UNLOCK_ADDR1);
                cyc_data = 8'h00;
            end
        endcase
        // Request address used by: plain read, program data step (step 3), short exit
        if (req_q.op == OP_READ) begin
            cyc_addr = req_q.addr;
        end else if (req_q.op == OP_ID_EXIT_SHORT) begin
            cyc_addr = req_q.addr;
            cyc_data = CMD_ID_EXIT;
        end else if (req_q.op == OP_PROGRAM && step_q == 3'd3) begin
            cyc_addr = req_q.addr;
            cyc_data = req_q.data;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Main sequencer
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= H_IDLE;
            req_q <= '{op: OP_READ, addr: '0, data: 8'h00};
            step_q <= 3'd0;
            have_prev_q <= 1'b0;
            prev_q <= 8'h00;
        end else begin
            unique case (state_q)
                H_IDLE: if (i_req_valid) begin
                    req_q <= i_req;
                    step_q <= 3'd0;
                    state_q <= H_ISSUE;
                end
                H_ISSUE: state_q <= H_WAIT;
                H_WAIT: if (cyc_done) begin
                    if (step_q == steps_total - 3'd1) begin
                        // Only program and erase start internal work
                        if (req_q.op == OP_PROGRAM
                            || req_q.op == OP_SECTOR_ERASE
                            || req_q.op == OP_CHIP_ERASE) begin
                            have_prev_q <= 1'b0;
                            state_q <= H_POLL_ISSUE;
                        end else begin
                            state_q <= H_FINISH;
                        end
                    end else begin
                        step_q <= step_q + 3'd1;
                        state_q <= H_ISSUE;
                    end
                end
                H_POLL_ISSUE: state_q <= H_POLL_WAIT;
                H_POLL_WAIT: if (cyc_done) begin
                    prev_q <= cyc_rdata;
                    have_prev_q <= 1'b1;
                    // Done once the toggle flag holds still between two reads in a row
                    if (have_prev_q && cyc_rdata[TOGGLE_BIT]
                        == prev_q[TOGGLE_BIT]) begin
                        state_q <= H_FINISH;
                    end else begin
                        state_q <= H_POLL_ISSUE;
                    end
                end
                H_FINISH: state_q <= H_IDLE;
                default: state_q <= H_IDLE;
            endcase
        end
    end

    // Mirror of the flash's ID mode; set or cleared in H_FINISH of an ID entry or exit request
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_id_mode <= 1'b0;
        end else if (state_q == H_FINISH) begin
            if (req_q.op == OP_ID_ENTRY) begin
                o_id_mode <= 1'b1;
            end else if (req_q.op == OP_ID_EXIT_SHORT
                         || req_q.op == OP_ID_EXIT_LONG) begin
                o_id_mode <= 1'b0;
            end
        end
    end

    // Response: read data, or last status byte after a write
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_resp_valid <= 1'b0;
            o_resp_data <= 8'h00;
        end else begin
            o_resp_valid <= (state_q == H_FINISH);
            if (state_q == H_FINISH) begin
                o_resp_data <= (req_q.op == OP_READ) ? cyc_rdata : prev_q;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus cycle engine and pin hookup
    assign cyc_start = (state_q == H_ISSUE) || (state_q == H_POLL_ISSUE);
    assign cyc_write = (state_q == H_ISSUE) && (req_q.op != OP_READ);
    assign o_req_ready = (state_q == H_IDLE);

    flash_bus_cycle u_cycle (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_start(cyc_start),
        .i_write(cyc_write),
        .i_addr(state_q == H_POLL_ISSUE ? req_q.addr : cyc_addr),
        .i_wdata(cyc_data),
        .i_dq(i_flash_dq),
        .o_busy(),
        .o_done(cyc_done),
        .o_rdata(cyc_rdata),
        .o_pins(pins)
    );

    // Host drives the data bus only during writes
    assign o_flash_ce_n = pins.ce_n;
    assign o_flash_oe_n = pins.oe_n;
    assign o_flash_we_n = pins.we_n;
    assign o_flash_addr = ADDR_WIDTH'(pins.addr);
    assign o_flash_dq = pins.dq_o;
    assign o_flash_dq_oe = pins.dq_oe;
endmodule

// ===== rtl/flash_host_pkg.sv
// Constants and carrier types for the parallel flash host controller.
// Assumes a 20 MHz system clock and a byte-wide asynchronous flash.
package flash_host_pkg;
    // Clock and bus timing
    localparam int CLK_MHZ = 20;
    localparam int MIN_PULSE_NS = 5;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    // Least times round up to whole cycles, never below two
    localparam int PULSE_RAW = (MIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (PULSE_RAW < 2) ? 2 : PULSE_RAW;
    localparam int READ_CYC = 2;
    localparam int ADDR_W = 19;
    localparam int SECTOR_LSB = 12;

    // Command sequence addresses and codes
    localparam logic [15:0] UNLOCK_ADDR1 = 16'h5555;
    localparam logic [15:0] UNLOCK_ADDR2 = 16'h2AAA;
    localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
    localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
    localparam logic [15:0] ID_MAKER_ADDR = 16'h0000;
    localparam logic [15:0] ID_PART_ADDR = 16'h0001;
    localparam int TOGGLE_BIT = 6;

    typedef enum logic [2:0] {
        OP_READ,
        OP_PROGRAM,
        OP_SECTOR_ERASE,
        OP_CHIP_ERASE,
        OP_ID_ENTRY,
        OP_ID_EXIT_SHORT,
        OP_ID_EXIT_LONG
    } op_t;

    // One user request
    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } req_t;

    // Flash pin bundle driven by the host
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [7:0] dq_o;
        logic dq_oe;
    } pins_t;
endpackage

// ===== testbench/flash_dev_model.sv
// Behavioural byte-wide flash with unlock sequences and toggle status.
// Assumes the bench resolves the data wire from the host's enable.
module flash_dev_model #(
    parameter int BUSY_NS = 2000,
    parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value
    parameter logic [7:0] PART_ID = 8'hA6 // Arbitrary value
)(
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [18:0] i_addr,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq,
    output logic o_busy = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [int];
    logic [18:0] la;
    logic [7:0] rd, ld, pd = 8'h00, last = 8'h00;
    logic [3:0] st = 4'h0;
    logic tog = 1'b0, er = 1'b0, id = 1'b0, wr = 1'b0;
    realtime t0;
    // Status while busy, codes in id mode, else the array
    always @* begin
        if (o_busy) rd = {~er & ~pd[7], tog, pd[5:0]};
        else if (id) rd = i_addr[0] ? PART_ID : MAKER_ID;
        else rd = mem.exists(i_addr) ? mem[i_addr] : 8'hFF;
    end
    // Released bus shows the inverse so a stale byte never passes
    assign o_dq = (!i_ce_n && !i_oe_n && i_we_n) ? rd : ~last;
    // Each finished read flips the flag while busy
    always @(posedge i_oe_n) begin
        last = rd;
        if (o_busy) tog = ~tog;
    end
    // Internal write time runs out on its own
    task automatic go_busy(input logic e);
        er = e;
        o_busy = 1'b1;
        fork
            #(BUSY_NS) o_busy = 1'b0;
        join_none
    endtask
    // Unlock decoder; the guard cannot be switched off
    task automatic do_write(input logic [18:0] a, input logic [7:0] d);
        logic u1, u2;
        u1 = a[14:0] == 15'h5555;
        u2 = a[14:0] == 15'h2AAA;
        if (o_busy) return;
        case (st)
            4'h0, 4'h3: st = (u1 && d == 8'hAA) ? st + 4'h1 : 4'h0;
            4'h1, 4'h4: st = (u2 && d == 8'h55) ? st + 4'h1 : 4'h0;
            4'h2: begin
                st = !u1 ? 4'h0 : d == 8'hA0 ? 4'h6 : d == 8'h80 ? 4'h3 : 4'h0;
                if (u1 && d == 8'h90) id = 1'b1;
                if (u1 && d == 8'hF0) id = 1'b0;
            end
            4'h5: begin
                st = 4'h0;
                foreach (mem[k]) begin
                    if ((d == 8'h10 && u1)
                        || (d == 8'h30 && k[18:12] == a[18:12]))
                        mem[k] = 8'hFF;
                end
                if ((d == 8'h10 && u1) || d == 8'h30) go_busy(1'b1);
            end
            default: begin
                st = 4'h0;
                mem[a] = mem.exists(a) ? mem[a] & d : d;
                pd = d;
                go_busy(1'b0);
            end
        endcase
        if (st == 4'h0 && d == 8'hF0) id = 1'b0;
    endtask
    // Write starts with select and strobe both low, ends at first rise
    always @(i_ce_n or i_we_n) begin
        if (!i_ce_n && !i_we_n && !wr) begin
            wr = 1'b1;
            t0 = $realtime;
            #1 la = i_addr;
            ld = i_dq;
        end else if (wr && (i_ce_n || i_we_n)) begin
            wr = 1'b0;
            if (i_oe_n && $realtime - t0 >= 5.0) do_write(la, ld);
        end
    end
endmodule

// ===== testbench/flash_host_checker.sv
// Checker of the flash host pins and request timing.
// Bound to flash_host_ctrl; sees its ports only, one clock domain.
module flash_host_checker
    import flash_host_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W
)(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    input wire req_t i_req,
    input wire logic o_req_ready,
    input wire logic o_resp_valid,
    input wire logic o_id_mode,
    input wire logic o_flash_ce_n,
    input wire logic o_flash_oe_n,
    input wire logic o_flash_we_n,
    input wire logic [ADDR_WIDTH-1:0] o_flash_addr,
    input wire logic [7:0] o_flash_dq,
    input wire logic o_flash_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    logic take;
    // Request taken at this edge
    assign take = i_req_valid && o_req_ready;
    //////////////////////////////////////////////////////////////////////
    // Strobe shapes
    sequence s_write_pulse;
        !o_flash_we_n ##1 o_flash_we_n;
    endsequence
    sequence s_read_pulse;
        !o_flash_oe_n ##1 o_flash_oe_n;
    endsequence
    chk_gate_strobe: assert property (
        !(!o_flash_ce_n && !o_flash_oe_n && !o_flash_we_n))
        else $error("strobe and gate low together");
    chk_write_width: assert property (
        $fell(o_flash_we_n) |-> !o_flash_ce_n ##1 s_write_pulse)
        else $error("write strobe width wrong");
    chk_read_width: assert property (
        $fell(o_flash_oe_n) |-> !o_flash_ce_n && o_flash_we_n
        ##1 s_read_pulse) else $error("read gate width wrong");
    chk_dq_drive: assert property (
        o_flash_dq_oe |-> !o_flash_we_n && o_flash_oe_n)
        else $error("host drives data outside a write");
    chk_write_held: assert property (
        !o_flash_we_n && $past(!o_flash_we_n) |->
        $stable(o_flash_addr) && $stable(o_flash_dq))
        else $error("address or data moved in a write");
    //////////////////////////////////////////////////////////////////////
    // Request timing
    chk_read_answer: assert property (
        take && i_req.op == OP_READ |-> ##7 o_resp_valid)
        else $error("read answer late");
    chk_busy_ready: assert property (
        take |=> !o_req_ready) else $error("ready while busy");
    chk_ready_resp: assert property (
        o_resp_valid |-> o_req_ready) else $error("not ready at answer");
    chk_id_entry: assert property (
        take && i_req.op == OP_ID_ENTRY |-> ##17 o_resp_valid
        ##1 o_id_mode) else $error("id entry wrong");
    chk_id_exit_long: assert property (
        take && i_req.op == OP_ID_EXIT_LONG |-> ##17 o_resp_valid
        ##1 !o_id_mode) else $error("long id exit wrong");
    chk_id_exit: assert property (
        take && i_req.op == OP_ID_EXIT_SHORT |-> ##7 o_resp_valid
        ##1 !o_id_mode) else $error("short id exit wrong");
endmodule

bind flash_host_ctrl flash_host_checker #(.ADDR_WIDTH(ADDR_WIDTH)) i_chk (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_resp_valid(o_resp_valid),
    .o_id_mode(o_id_mode), .o_flash_ce_n(o_flash_ce_n),
    .o_flash_oe_n(o_flash_oe_n), .o_flash_we_n(o_flash_we_n),
    .o_flash_addr(o_flash_addr), .o_flash_dq(o_flash_dq),
    .o_flash_dq_oe(o_flash_dq_oe));

// ===== testbench/tb_top.sv
// Self-checking bench of the flash host controller.
// Assumes the model and checker files are compiled before it.
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
    errors++; $display("wrong value %s exp %h got %h", nm, e, s); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_host_pkg::*;
    localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
    localparam logic [7:0] PART = 8'hA6; // Arbitrary value
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_req_valid = 1'b0;
    req_t i_req = '0;
    logic ready, rv, idm, ce_n, oe_n, we_n, dq_oe, busy;
    logic [7:0] rdat, dq_h, dq_m, dq, r;
    logic [18:0] addr;
    int errors = 0, n_compared = 0, cyc = 0;
    always #25 i_mclk = ~i_mclk;
    // Data wire: host while its enable is up, else the flash
    assign dq = dq_oe ? dq_h : dq_m;
    flash_host_ctrl i_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(ready),
        .o_resp_valid(rv), .o_resp_data(rdat), .o_id_mode(idm),
        .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n),
        .o_flash_addr(addr), .i_flash_dq(dq), .o_flash_dq(dq_h),
        .o_flash_dq_oe(dq_oe));
    flash_dev_model #(.MAKER_ID(MAKER), .PART_ID(PART)) i_model (
        .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr),
        .i_dq(dq), .o_dq(dq_m), .o_busy(busy));
    //////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 10000) begin
            errors++;
            close_out();
        end
    end
    // One request, held until taken, then wait for its answer
    task automatic do_op(input op_t op, input logic [18:0] a,
                         input logic [7:0] d);
        int n;
        @(negedge i_mclk);
        i_req_valid = 1'b1;
        i_req = '{op: op, addr: a, data: d};
        // Ready moves only at rising edges, so a falling-edge look is safe
        while (ready !== 1'b1) @(negedge i_mclk);
        @(posedge i_mclk);
        @(negedge i_mclk);
        i_req_valid = 1'b0;
        for (n = 0; n < 3000 && rv !== 1'b1; n++) @(negedge i_mclk);
        `CHK("answer", 1'b1, rv)
        r = rdat;
    endtask
    //////////////////////////////////////////////////////////////////////
    task automatic t_program();
        do_op(OP_PROGRAM, 19'h01234, 8'h5A);
        `CHK("status", 8'h5A, r)
        `CHK("busy", 1'b0, busy)
        do_op(OP_READ, 19'h01234, 8'h00);
        `CHK("prog", 8'h5A, r)
    endtask
    task automatic t_sector();
        do_op(OP_PROGRAM, 19'h13005, 8'h00);
        do_op(OP_SECTOR_ERASE, 19'h13ABC, 8'h00);
        `CHK("erase status", 8'hFF, r)
        do_op(OP_READ, 19'h13005, 8'h00);
        `CHK("erased", 8'hFF, r)
        do_op(OP_READ, 19'h01234, 8'h00);
        `CHK("kept", 8'h5A, r)
    endtask
    task automatic t_chip();
        do_op(OP_CHIP_ERASE, 19'h00000, 8'h00);
        do_op(OP_READ, 19'h01234, 8'h00);
        `CHK("chip", 8'hFF, r)
    endtask
    task automatic t_id(input op_t ex);
        do_op(OP_ID_ENTRY, 19'h00000, 8'h00);
        `CHK("id on", 1'b1, idm)
        do_op(OP_READ, 19'h00000, 8'h00);
        `CHK("maker", MAKER, r)
        do_op(OP_READ, 19'h00001, 8'h00);
        `CHK("part", PART, r)
        do_op(ex, 19'h00777, 8'hF0);
        `CHK("id off", 1'b0, idm)
        do_op(OP_READ, 19'h00001, 8'h00);
        `CHK("array", 8'hFF, r)
    endtask
    initial begin
        repeat (5) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        t_program();
        t_sector();
        t_chip();
        t_id(OP_ID_EXIT_SHORT);
        t_id(OP_ID_EXIT_LONG);
        close_out();
    end
endmodule
